//--- hdl/role_auth_gate.sv
/*
 * role gate: tracks the active role, counts failed attempts, triggers
 * erase, and passes media traffic through an 8-word fifo only when the
 * user role is active. assumes the failure count is mirrored in
 * nonvolatile storage by the caller via fail_cnt/fail_restore.
 */
`timescale 1ns/1ps

module gate_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             flush,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    // refused at elaboration: pointers wrap on a power of two only
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("fifo depth must be a power of two >= 2");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;
    assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid = wr_q != rd_q;
    assign out_data  = mem[rd_q[AW-1:0]];
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else if (flush) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push)
                wr_q <= wr_q + 1'b1;
            if (pop)
                rd_q <= rd_q + 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (push)
            mem[wr_q[AW-1:0]] <= in_data;
    end
endmodule

module role_auth_gate #(
    parameter int DATA_W = auth_gate_pkg::DATA_W,
    parameter int DEPTH  = auth_gate_pkg::FIFO_DEPTH
) (
    input  wire logic              clk,
    input  wire logic              reset_n,
    // authentication requests (one-cycle pulses)
    input  wire logic              cfg_auth_req,
    input  wire logic              cfg_pw_match,
    input  wire logic              user_auth_req,
    input  wire logic              user_pw_match,
    input  wire logic [6:0]        user_pw_len,
    input  wire logic              session_key_mode,
    input  wire logic              key_halves_differ,
    input  wire logic              logout_req,
    // nonvolatile failure count mirror
    input  wire logic              fail_restore,
    input  wire logic [3:0]        fail_nv_in,
    output logic       [3:0]       fail_cnt,
    // results
    output logic                   auth_ok,
    output logic                   auth_fail,
    output logic                   role_cfg,
    output logic                   role_user,
    output logic                   erase_req,
    input  wire logic              erase_done,
    // configuration command gate
    input  wire logic              cfg_cmd_valid,
    output logic                   cfg_cmd_accept,
    output logic                   cfg_cmd_reject,
    // host write stream to encrypt/media path
    input  wire logic              wr_valid,
    output logic                   wr_ready,
    input  wire logic [DATA_W-1:0] wr_data,
    output logic                   wr_refused,
    output logic                   enc_valid,
    input  wire logic              enc_ready,
    output logic      [DATA_W-1:0] enc_data,
    // host read requests
    input  wire logic              rd_req,
    output logic                   rd_grant,
    output logic                   rd_refused
);
    auth_gate_pkg::role_e role_q;
    auth_gate_pkg::role_e role_d;
    logic [3:0] fail_q;
    logic       ok_q;
    logic       fail_ev_q;

    // password length, or distinct key halves in session key mode, checked before matching
    wire pw_len_ok = user_pw_len >= auth_gate_pkg::PW_MIN_BYTES &&
                     user_pw_len <= auth_gate_pkg::PW_MAX_BYTES;
    wire user_cred = session_key_mode ? key_halves_differ
                                      : pw_len_ok;
    wire erasing   = role_q == auth_gate_pkg::ST_ERASE;
    wire cfg_try   = cfg_auth_req && !erasing;
    wire user_try  = user_auth_req && !cfg_auth_req && !erasing;
    wire try_ok    = (cfg_try && cfg_pw_match) ||
                     (user_try && user_pw_match && user_cred);
    wire try_bad   = (cfg_try || user_try) && !try_ok;
    wire at_limit  = try_bad &&
                     fail_q == auth_gate_pkg::FAIL_LIMIT - 4'h1;

    always_comb begin
        role_d = role_q;
        unique case (role_q)
            auth_gate_pkg::ST_LOCKED,
            auth_gate_pkg::ST_CONFIG,
            auth_gate_pkg::ST_USER: begin
                if (at_limit)
                    role_d = auth_gate_pkg::ST_ERASE;
                else if (cfg_try && cfg_pw_match)
                    role_d = auth_gate_pkg::ST_CONFIG;
                else if (try_ok)
                    role_d = auth_gate_pkg::ST_USER;
                else if (try_bad || logout_req)
                    role_d = auth_gate_pkg::ST_LOCKED;
            end
            auth_gate_pkg::ST_ERASE: begin
                if (erase_done)
                    role_d = auth_gate_pkg::ST_LOCKED;
            end
            default: role_d = auth_gate_pkg::ST_LOCKED;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            role_q <= auth_gate_pkg::ST_LOCKED;
        else
            role_q <= role_d;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            fail_q <= auth_gate_pkg::FAIL_RESET;
        else if (fail_restore)
            fail_q <= fail_nv_in;
        else if (try_ok || (erasing && erase_done))
            fail_q <= auth_gate_pkg::FAIL_RESET;
        else if (try_bad && fail_q != auth_gate_pkg::FAIL_LIMIT)
            fail_q <= fail_q + 4'h1;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ok_q      <= 1'b0;
            fail_ev_q <= 1'b0;
        end else begin
            ok_q      <= try_ok;
            fail_ev_q <= try_bad;
        end
    end

    wire is_user = role_q == auth_gate_pkg::ST_USER;
    wire is_cfg  = role_q == auth_gate_pkg::ST_CONFIG;
    assign fail_cnt  = fail_q;
    assign auth_ok   = ok_q;
    assign auth_fail = fail_ev_q;
    assign role_cfg  = is_cfg;
    assign role_user = is_user;
    assign erase_req = erasing;

    assign cfg_cmd_accept = cfg_cmd_valid && is_cfg;
    assign cfg_cmd_reject = cfg_cmd_valid && !is_cfg;

    // media path only open to the authenticated user
    wire fifo_in_ready;
    assign wr_ready   = is_user && fifo_in_ready;
    assign wr_refused = wr_valid && !is_user;
    assign rd_grant   = rd_req && is_user;
    assign rd_refused = rd_req && !is_user;

    gate_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (clk),
        .reset_n   (reset_n),
        .flush     (!is_user),
        .in_valid  (wr_valid && is_user),
        .in_ready  (fifo_in_ready),
        .in_data   (wr_data),
        .out_valid (enc_valid),
        .out_ready (enc_ready),
        .out_data  (enc_data)
    );

    property p_no_media_locked;
        @(posedge clk) disable iff (!reset_n)
        !is_user |-> !wr_ready && !rd_grant;
    endproperty
    a_no_media_locked: assert property (p_no_media_locked)
        else $error("media access while not user");

    property p_one_role;
        @(posedge clk) disable iff (!reset_n)
        !(role_cfg && role_user);
    endproperty
    a_one_role: assert property (p_one_role)
        else $error("two roles active");

    property p_cfg_only;
        @(posedge clk) disable iff (!reset_n)
        cfg_cmd_valid && !role_cfg |-> !cfg_cmd_accept;
    endproperty
    a_cfg_only: assert property (p_cfg_only)
        else $error("config command outside config role");

    property p_user_after_ok;
        @(posedge clk) disable iff (!reset_n)
        $rose(role_user) |-> auth_ok;
    endproperty
    a_user_after_ok: assert property (p_user_after_ok)
        else $error("user role without authentication");

    property p_erase_at_limit;
        @(posedge clk) disable iff (!reset_n)
        at_limit && !fail_restore |=> erase_req && fail_cnt == 4'hF;
    endproperty
    a_erase_at_limit: assert property (p_erase_at_limit)
        else $error("limit reached without erase");

    property p_clear_on_ok;
        @(posedge clk) disable iff (!reset_n)
        try_ok && !fail_restore |=> fail_cnt == 4'h0 ##0 auth_ok;
    endproperty
    a_clear_on_ok: assert property (p_clear_on_ok)
        else $error("fail count not cleared");

    property p_fail_count;
        @(posedge clk) disable iff (!reset_n)
        try_bad && !fail_restore && fail_q < 4'hF
            |=> fail_cnt == $past(fail_q) + 4'h1;
    endproperty
    a_fail_count: assert property (p_fail_count)
        else $error("failure not counted");

    property p_short_pw;
        @(posedge clk) disable iff (!reset_n)
        user_try && !session_key_mode && user_pw_len < 7'h08
            |=> !role_user;
    endproperty
    a_short_pw: assert property (p_short_pw)
        else $error("short password accepted");

    property p_same_halves;
        @(posedge clk) disable iff (!reset_n)
        user_try && session_key_mode && !key_halves_differ
            |=> auth_fail;
    endproperty
    a_same_halves: assert property (p_same_halves)
        else $error("equal key halves accepted");
endmodule

//--- hdl/auth_gate_pkg.sv
/*
 * constants and types shared by the role gate and its data fifo.
 * assumes a single 250 MHz clock domain; secrets are compared upstream
 * as hashed digests, so this block only sees match results.
 */
package auth_gate_pkg;

    typedef enum logic [3:0] {
        ST_LOCKED = 4'b0001,
        ST_CONFIG = 4'b0010,
        ST_USER   = 4'b0100,
        ST_ERASE  = 4'b1000
    } role_e;

    localparam logic [3:0] FAIL_LIMIT   = 4'hF;
    localparam logic [3:0] FAIL_RESET   = 4'h0;
    localparam int         KEY_HALF_W   = 256;
    localparam logic [6:0] PW_MIN_BYTES = 7'h08;
    localparam logic [6:0] PW_MAX_BYTES = 7'h40;
    localparam int         DATA_W       = 32;
    localparam int         FIFO_DEPTH   = 8;

endpackage

//--- test/media_sink.sv
/*
 * far side model: cipher/media sink with stall control and an erase
 * responder. assumes the gate's clock, reset and stream ports.
 */
`timescale 1ns/1ps

module media_sink (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // bench control
    input  wire logic        stall,
    // cipher stream
    input  wire logic        enc_valid,
    output logic             enc_ready,
    input  wire logic [31:0] enc_data,
    // erase handshake
    input  wire logic        erase_req,
    output logic             erase_done
);
    logic [31:0] got[$];
    logic [2:0]  wait_q;

    assign enc_ready = !stall;

    // erase takes a few cycles, then one done pulse
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wait_q     <= 3'h0;
            erase_done <= 1'b0;
        end else begin
            erase_done <= erase_req && wait_q == 3'h3;
            wait_q     <= erase_req ? wait_q + 3'h1 : 3'h0;
            if (enc_valid && enc_ready) got.push_back(enc_data);
        end
    end
endmodule

//--- test/test_role_auth_gate.sv
/*
 * self-checking bench for the role gate: table of auth attempts, then
 * gating, fifo fill/drain and erase. assumes media_sink as far side.
 */
`timescale 1ns/1ps

module test_role_auth_gate;
    typedef struct packed {
        logic [12:0] a;
        logic        ok;
        logic [1:0]  role;
    } row_s;
    logic clk = 0, reset_n = 0, cfg_auth_req = 0, cfg_pw_match = 0;
    logic user_auth_req = 0, user_pw_match = 0, session_key_mode = 0;
    logic key_halves_differ = 0, logout_req = 0, fail_restore = 0;
    logic cfg_cmd_valid = 0, wr_valid = 0, rd_req = 0, stall = 0;
    logic [6:0]  user_pw_len = 7'h00;
    logic [3:0]  fail_nv_in = 4'h0, fail_cnt;
    logic [31:0] wr_data = 32'h0000_0000, enc_data;
    logic auth_ok, auth_fail, role_cfg, role_user, erase_req, erase_done;
    logic cfg_cmd_accept, cfg_cmd_reject, wr_ready, wr_refused;
    logic enc_valid, enc_ready, rd_grant, rd_refused;
    int n_fail = 0, checks = 0, cyc = 0, exp_cnt = 0;
    row_s rows[10] = '{
        '{{4'b1100, 7'h00, 2'b00}, 1'b1, 2'b10},
        '{{4'b0011, 7'h08, 2'b00}, 1'b1, 2'b01},
        '{{4'b0011, 7'h07, 2'b00}, 1'b0, 2'b00},
        '{{4'b0011, 7'h40, 2'b00}, 1'b1, 2'b01},
        '{{4'b0011, 7'h41, 2'b00}, 1'b0, 2'b00},
        '{{4'b0011, 7'h08, 2'b11}, 1'b1, 2'b01},
        '{{4'b0011, 7'h08, 2'b10}, 1'b0, 2'b00},
        '{{4'b1000, 7'h00, 2'b00}, 1'b0, 2'b00},
        '{{4'b0010, 7'h08, 2'b00}, 1'b0, 2'b00},
        '{{4'b1100, 7'h00, 2'b00}, 1'b1, 2'b10}};

    always #2 clk = ~clk;

    role_auth_gate role_auth_gate_i (
        .clk               (clk),
        .reset_n           (reset_n),
        .cfg_auth_req      (cfg_auth_req),
        .cfg_pw_match      (cfg_pw_match),
        .user_auth_req     (user_auth_req),
        .user_pw_match     (user_pw_match),
        .user_pw_len       (user_pw_len),
        .session_key_mode  (session_key_mode),
        .key_halves_differ (key_halves_differ),
        .logout_req        (logout_req),
        .fail_restore      (fail_restore),
        .fail_nv_in        (fail_nv_in),
        .fail_cnt          (fail_cnt),
        .auth_ok           (auth_ok),
        .auth_fail         (auth_fail),
        .role_cfg          (role_cfg),
        .role_user         (role_user),
        .erase_req         (erase_req),
        .erase_done        (erase_done),
        .cfg_cmd_valid     (cfg_cmd_valid),
        .cfg_cmd_accept    (cfg_cmd_accept),
        .cfg_cmd_reject    (cfg_cmd_reject),
        .wr_valid          (wr_valid),
        .wr_ready          (wr_ready),
        .wr_data           (wr_data),
        .wr_refused        (wr_refused),
        .enc_valid         (enc_valid),
        .enc_ready         (enc_ready),
        .enc_data          (enc_data),
        .rd_req            (rd_req),
        .rd_grant          (rd_grant),
        .rd_refused        (rd_refused)
    );
    media_sink media_sink_i (
        .clk        (clk),
        .reset_n    (reset_n),
        .stall      (stall),
        .enc_valid  (enc_valid),
        .enc_ready  (enc_ready),
        .enc_data   (enc_data),
        .erase_req  (erase_req),
        .erase_done (erase_done)
    );

    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            wrap_up();
        end
    end

    task automatic chk_bit(string what, logic exp, logic got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s exp %b got %b", what, exp, got);
        end
    endtask

    task automatic chk_word(string what, logic [31:0] exp, logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask

    // one attempt; returns just after the answer edge
    task automatic attempt(logic [12:0] a);
        {cfg_auth_req, cfg_pw_match, user_auth_req, user_pw_match,
         user_pw_len, session_key_mode, key_halves_differ} = a;
        @(posedge clk);
        #1;
        {cfg_auth_req, user_auth_req} = 2'b00;
    endtask

    task automatic wrap_up();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk);
        #1;
        reset_n = 1;
        chk_bit("role_cfg", 1'b0, role_cfg);
        chk_bit("role_user", 1'b0, role_user);
        $display("reset done");
        foreach (rows[i]) begin
            attempt(rows[i].a);
            exp_cnt = rows[i].ok ? 0 : exp_cnt + 1;
            chk_bit("auth_ok", rows[i].ok, auth_ok);
            chk_bit("auth_fail", !rows[i].ok, auth_fail);
            chk_bit("role_cfg", rows[i].role[1], role_cfg);
            chk_bit("role_user", rows[i].role[0], role_user);
            chk_word("fail_cnt", exp_cnt, 32'(fail_cnt));
            @(posedge clk);
            #1;
        end
        $display("table done");
        cfg_cmd_valid = 1;
        rd_req = 1;
        wr_valid = 1;
        #1;
        chk_bit("cfg_cmd_accept", 1'b1, cfg_cmd_accept);
        chk_bit("rd_refused cfg", 1'b1, rd_refused);
        chk_bit("wr_ready cfg", 1'b0, wr_ready);
        logout_req = 1;
        @(posedge clk);
        #1;
        logout_req = 0;
        chk_bit("wr_refused", 1'b1, wr_refused);
        chk_bit("rd_refused", 1'b1, rd_refused);
        chk_bit("rd_grant", 1'b0, rd_grant);
        wr_valid = 0;
        attempt({4'b0011, 7'h08, 2'b00});
        chk_bit("cfg_cmd_reject", 1'b1, cfg_cmd_reject);
        chk_bit("rd_grant", 1'b1, rd_grant);
        {cfg_cmd_valid, rd_req, stall} = 3'b001;
        $display("gating done");
        // ninth word waits on the full fifo until the sink drains
        for (int i = 0; i < 9; i++) begin
            wr_valid = 1;
            wr_data = 32'hA5A5_0000 + i;
            #1;
            chk_bit("wr_ready", i < 8, wr_ready);
            chk_bit("enc_valid", i > 0, enc_valid);
            @(posedge clk);
            #1;
        end
        stall = 0;
        @(posedge clk);
        #1;
        chk_bit("wr_ready freed", 1'b1, wr_ready);
        @(posedge clk);
        #1;
        wr_valid = 0;
        for (int i = 0; i < 40 && media_sink_i.got.size() < 9; i++)
            @(posedge clk);
        chk_word("drained", 9, media_sink_i.got.size());
        foreach (media_sink_i.got[i])
            chk_word("enc_data", 32'hA5A5_0000 + i,
                     media_sink_i.got[i]);
        #1;
        $display("fifo done");
        fail_nv_in = 4'hD;
        fail_restore = 1;
        @(posedge clk);
        #1;
        fail_restore = 0;
        attempt({4'b0010, 7'h08, 2'b00});
        chk_word("fail_cnt 14", 14, 32'(fail_cnt));
        chk_bit("no erase", 1'b0, erase_req);
        @(posedge clk);
        #1;
        attempt({4'b0010, 7'h08, 2'b00});
        #1;
        chk_bit("erase_req", 1'b1, erase_req);
        chk_word("fail_cnt 15", 15, 32'(fail_cnt));
        attempt({4'b0011, 7'h08, 2'b00});
        chk_bit("ok in erase", 1'b0, auth_ok);
        for (int i = 0; i < 20 && erase_req; i++)
            @(posedge clk);
        #1;
        chk_bit("erase end", 1'b0, erase_req);
        chk_word("fail_cnt 0", 0, 32'(fail_cnt));
        chk_bit("role_user", 1'b0, role_user);
        $display("erase done");
        // mid-run reset with a word parked and a restored count
        attempt({4'b0011, 7'h08, 2'b00});
        {stall, wr_valid, fail_restore} = 3'b111;
        @(posedge clk);
        #1;
        {wr_valid, fail_restore} = 2'b00;
        chk_bit("enc_valid parked", 1'b1, enc_valid);
        chk_word("fail_cnt 13", 13, 32'(fail_cnt));
        reset_n = 0;
        @(posedge clk);
        #1;
        reset_n = 1;
        chk_bit("role_user rst", 1'b0, role_user);
        chk_bit("enc_valid rst", 1'b0, enc_valid);
        chk_word("fail_cnt rst", 0, 32'(fail_cnt));
        stall = 0;
        $display("reset2 done");
        wrap_up();
    end
endmodule
